// file: verilog/pfc_pkg.sv
// pfc_pkg: flag layout, operation codes and carriers for the flags register block
// assumes: included before the flags unit and its index stepper
`default_nettype none
package pfc_pkg;
  // flag bit positions
  localparam int CARRY_POS      = 0;
  localparam int PARITY_POS     = 2;
  localparam int AUX_POS        = 4;
  localparam int ZERO_POS       = 6;
  localparam int SIGN_POS       = 7;
  localparam int TRAP_POS       = 8;
  localparam int INTEN_POS      = 9;
  localparam int DIR_POS        = 10;
  localparam int OVF_POS        = 11;
  localparam int IO_PRIVILEGE_LEVEL_LO_POS    = 12;
  localparam int IO_PRIVILEGE_LEVEL_HI_POS    = 13;
  localparam int RESUME_POS     = 16;
  localparam int V86_POS        = 17;
  localparam int ALIGN_POS      = 18;
  localparam int FEATQ_POS      = 21;
  localparam int FEATURE_LS_POS = 0;
  // reset value: bit 1 always reads one
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [31:0] FIXED_ONES  = 32'h0000_0002;
  // write masks
  localparam logic [31:0] POP_BASE_MASK = 32'h0000_0dd5;
  localparam logic [31:0] POP_IO_PRIVILEGE_LEVEL_MASK = 32'h0000_3000;
  localparam logic [31:0] POP_IE_MASK   = 32'h0000_0200;
  localparam logic [31:0] POP32_XMASK   = 32'h0024_0000;
  localparam logic [31:0] PUSH_CLR_MASK = 32'h0003_0000;
  localparam logic [7:0]  BYTE_MASK     = 8'hd5;
  localparam logic [1:0]  PRIV_KERNEL   = 2'h0;

  typedef enum logic [3:0] {
    PFC_NOP = 4'h0, PFC_SET_CARRY = 4'h1, PFC_CLR_CARRY = 4'h2, PFC_INV_CARRY = 4'h3,
    PFC_SET_DIR = 4'h4, PFC_CLR_DIR = 4'h5, PFC_SET_IE = 4'h6, PFC_CLR_IE = 4'h7,
    PFC_LOAD_BYTE = 4'h8, PFC_STORE_BYTE = 4'h9, PFC_PUSH16 = 4'ha, PFC_PUSH32 = 4'hb,
    PFC_POP16 = 4'hc, PFC_POP32 = 4'hd, PFC_STEP = 4'he
  } pfc_op_t;

  typedef struct packed {
    pfc_op_t     op;
    logic [63:0] popData;
    logic [7:0]  accHigh;
    logic [2:0]  stepSize;
  } pfc_req_t;

  typedef struct packed {
    logic [1:0] currentPrivilegeLevel;
    logic       longMode;
    logic       featureLoadStore;
    logic       v86Mode;
  } pfc_mode_t;
endpackage
`default_nettype wire

// file: verilog/pfc_index_step.sv
// pfc_index_step: string source/destination index stepper
// assumes: step pulse from the flags unit, direction from the current flag state
`timescale 1ns/100ps
`default_nettype none
module pfc_index_step import pfc_pkg::*; #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             step,
  input  wire logic             directionFlag,
  input  wire logic [2:0]       stepSize,
  input  wire logic             loadIdx,
  input  wire logic [WIDTH-1:0] loadSource,
  input  wire logic [WIDTH-1:0] loadDest,
  // indices
  output logic      [WIDTH-1:0] stringSourceIndex,
  output logic      [WIDTH-1:0] stringDestinationIndex
);
  logic [WIDTH-1:0] delta;
  assign delta = WIDTH'(stepSize);

  always_ff @(posedge clk) begin
    if (rst) begin
      stringSourceIndex      <= '0;
      stringDestinationIndex <= '0;
    end else if (loadIdx) begin
      stringSourceIndex      <= loadSource;
      stringDestinationIndex <= loadDest;
    end else if (step) begin
      // up when clear, down when set
      stringSourceIndex      <= directionFlag ? stringSourceIndex - delta : stringSourceIndex + delta;
      stringDestinationIndex <= directionFlag ? stringDestinationIndex - delta : stringDestinationIndex + delta;
    end
  end

  property p_step_dir;
    @(posedge clk) disable iff (rst)
    (step && !loadIdx) |=> stringSourceIndex ==
      ($past(directionFlag) ? $past(stringSourceIndex) - $past(delta) : $past(stringSourceIndex) + $past(delta));
  endproperty
  a_step_dir: assert property (p_step_dir) else $error("index step direction wrong");
endmodule // pfc_index_step
`default_nettype wire

// file: verilog/pfc_flags_unit.sv
// pfc_flags_unit: processor flags register with flag control, byte transfer, push and pop
// assumes: one request per valid cycle, mode inputs stable, same clock as the core
//
// Function
// - set, clear and invert operations on the carry flag.
// - set and clear operations on the direction flag only.
// - string indices increment when direction clear, decrement when set.
// - byte load puts sign, zero, aux, parity, carry at 7,6,4,2,0.
// - byte load bits 5, 3, 1 are undefined; do not check.
// - byte store copies bits 7,6,4,2,0 into the five status flags.
// - 16-bit push writes only the lower flags word.
// - 32-bit push writes all flags with resume and virtual-8086 zero.
// - 16-bit pop always updates bits 11,10,8,7,6,4,2,0.
// - pop updates io privilege field only at current privilege zero.
// - pop updates interrupt enable only when io privilege >= current privilege.
// - 32-bit pop also updates alignment check and feature query bits.
// - direct set and clear of interrupt enable, gated by mode and privilege.
// - interrupt enable one services the request pin, zero masks it.
// - long mode byte load/store only when feature bit 0 is one.
// - long mode wide push writes full 64 bits, resume and v86 zero.
// - long mode wide pop loads low 32 under masks, zeroes upper.
`timescale 1ns/100ps
`default_nettype none
module pfc_flags_unit import pfc_pkg::*; #(
  parameter int IDX_WIDTH = 64
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // request
  input  wire logic                 reqValid,
  input  wire pfc_req_t             req,
  input  wire pfc_mode_t            mode,
  // index preload
  input  wire logic                 loadIdx,
  input  wire logic [IDX_WIDTH-1:0] loadSource,
  input  wire logic [IDX_WIDTH-1:0] loadDest,
  // interrupt pin
  input  wire logic                 hardwareInterruptRequestPin,
  // results
  output logic                      done,
  output logic                      fault,
  output logic [7:0]                accumulatorHighByte,
  output logic                      pushValid,
  output logic [63:0]               pushData,
  output logic [31:0]               processorFlags,
  output logic                      interruptService,
  output logic [IDX_WIDTH-1:0]      stringSourceIndex,
  output logic [IDX_WIDTH-1:0]      stringDestinationIndex
);
  logic [31:0] next_flags;
  logic        opFault;
  logic        irqMeta;
  logic        irqSync;
  logic        ieAllowed;
  logic [1:0]  io_privilege_level;
  logic [31:0] popMask;
  logic [31:0] popWord;

  // io privilege field of a flags word
  function automatic logic [1:0] ioplOf(input logic [31:0] f);
    ioplOf = f[IO_PRIVILEGE_LEVEL_HI_POS:IO_PRIVILEGE_LEVEL_LO_POS];
  endfunction

  assign io_privilege_level = ioplOf(processorFlags);
  // direct interrupt-enable writes need enough io privilege, never in v86 here
  assign ieAllowed = !mode.v86Mode && (io_privilege_level >= mode.currentPrivilegeLevel);

  // pop write mask
  always_comb begin
    popMask = POP_BASE_MASK;
    if (mode.currentPrivilegeLevel == PRIV_KERNEL) begin
      popMask = popMask | POP_IO_PRIVILEGE_LEVEL_MASK;
    end
    if (io_privilege_level >= mode.currentPrivilegeLevel) begin
      popMask = popMask | POP_IE_MASK;
    end
    if (req.op == PFC_POP32) begin
      popMask = popMask | POP32_XMASK;
    end
    // 16-bit pop sees only the low word; wide pop takes low 32 bits
    popWord = (req.op == PFC_POP16) ? {16'h0000, req.popData[15:0]} : req.popData[31:0];
  end

  // all changes merge into one next value, written on one edge
  always_comb begin
    next_flags = processorFlags;
    opFault    = 1'b0;
    case (req.op)
      PFC_SET_CARRY:  next_flags[CARRY_POS] = 1'b1;
      PFC_CLR_CARRY:  next_flags[CARRY_POS] = 1'b0;
      PFC_INV_CARRY:  next_flags[CARRY_POS] = ~processorFlags[CARRY_POS];
      PFC_SET_DIR:    next_flags[DIR_POS] = 1'b1;
      PFC_CLR_DIR:    next_flags[DIR_POS] = 1'b0;
      PFC_SET_IE, PFC_CLR_IE: begin
        if (ieAllowed) begin
          next_flags[INTEN_POS] = (req.op == PFC_SET_IE);
        end else begin
          opFault = 1'b1;
        end
      end
      PFC_LOAD_BYTE: begin
        opFault = mode.longMode && !mode.featureLoadStore;
      end
      PFC_STORE_BYTE: begin
        if (mode.longMode && !mode.featureLoadStore) begin
          opFault = 1'b1;
        end else begin
          next_flags[7:0] = (processorFlags[7:0] & ~BYTE_MASK) | (req.accHigh & BYTE_MASK);
        end
      end
      PFC_POP16, PFC_POP32: begin
        next_flags = (processorFlags & ~popMask) | (popWord & popMask) | FIXED_ONES;
      end
      default: next_flags = processorFlags;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      processorFlags <= FLAGS_RESET;
    end else if (reqValid) begin
      processorFlags <= next_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done  <= 1'b0;
      fault <= 1'b0;
    end else begin
      done  <= reqValid;
      fault <= reqValid && opFault;
    end
  end

  // undefined bits 5, 3, 1 driven zero here
  always_ff @(posedge clk) begin
    if (rst) begin
      accumulatorHighByte <= 8'h00;
    end else if (reqValid && req.op == PFC_LOAD_BYTE && !opFault) begin
      accumulatorHighByte <= processorFlags[7:0] & BYTE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pushValid <= 1'b0;
      pushData  <= 64'h0;
    end else begin
      pushValid <= reqValid && (req.op == PFC_PUSH16 || req.op == PFC_PUSH32);
      if (reqValid && req.op == PFC_PUSH16) begin
        pushData <= {48'h0, processorFlags[15:0]};
      end else if (reqValid && req.op == PFC_PUSH32) begin
        // upper word zero: flags above 31 do not exist
        pushData <= {32'h0, processorFlags & ~PUSH_CLR_MASK};
      end
    end
  end

  // request pin is asynchronous: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      irqMeta <= 1'b0;
      irqSync <= 1'b0;
    end else begin
      irqMeta <= hardwareInterruptRequestPin;
      irqSync <= irqMeta;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interruptService <= 1'b0;
    end else begin
      interruptService <= irqSync && processorFlags[INTEN_POS];
    end
  end

  pfc_index_step #(
    .WIDTH(IDX_WIDTH)
  ) u_step (
    .clk                   (clk),
    .rst                   (rst),
    .step                  (reqValid && req.op == PFC_STEP),
    .directionFlag         (processorFlags[DIR_POS]),
    .stepSize              (req.stepSize),
    .loadIdx               (loadIdx),
    .loadSource            (loadSource),
    .loadDest              (loadDest),
    .stringSourceIndex     (stringSourceIndex),
    .stringDestinationIndex(stringDestinationIndex)
  );

  property p_carry_inv;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_INV_CARRY) |=> processorFlags[CARRY_POS] != $past(processorFlags[CARRY_POS]);
  endproperty
  a_carry_inv: assert property (p_carry_inv) else $error("carry not inverted");

  property p_dir_only;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_SET_DIR) |=>
      processorFlags[DIR_POS] && ((processorFlags ^ $past(processorFlags)) & ~32'h0000_0400) == 32'h0;
  endproperty
  a_dir_only: assert property (p_dir_only) else $error("direction set disturbed other flags");

  property p_load_byte;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_LOAD_BYTE && !mode.longMode) |=>
      (accumulatorHighByte & BYTE_MASK) == ($past(processorFlags[7:0]) & BYTE_MASK) && $stable(processorFlags);
  endproperty
  a_load_byte: assert property (p_load_byte) else $error("byte load mismatch");

  property p_store_byte;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_STORE_BYTE && !mode.longMode) |=>
      (processorFlags[7:0] & BYTE_MASK) == ($past(req.accHigh) & BYTE_MASK);
  endproperty
  a_store_byte: assert property (p_store_byte) else $error("byte store mismatch");

  property p_push16;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_PUSH16) |=> pushValid && pushData == {48'h0, $past(processorFlags[15:0])};
  endproperty
  a_push16: assert property (p_push16) else $error("16-bit push wrong");

  property p_push32;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_PUSH32) |=> pushValid && !pushData[RESUME_POS] && !pushData[V86_POS]
      && pushData[15:0] == $past(processorFlags[15:0]);
  endproperty
  a_push32: assert property (p_push32) else $error("32-bit push wrong");

  property p_pop_base;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_POP16) |=>
      (processorFlags & POP_BASE_MASK) == ($past(req.popData[31:0]) & POP_BASE_MASK);
  endproperty
  a_pop_base: assert property (p_pop_base) else $error("pop base bits wrong");

  property p_pop_io_privilege_level;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_POP16 || req.op == PFC_POP32) && mode.currentPrivilegeLevel != PRIV_KERNEL)
      |=> $stable(processorFlags[IO_PRIVILEGE_LEVEL_HI_POS:IO_PRIVILEGE_LEVEL_LO_POS]);
  endproperty
  a_pop_io_privilege_level: assert property (p_pop_io_privilege_level) else $error("io privilege changed without kernel");

  property p_pop_ie;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_POP16 || req.op == PFC_POP32) && io_privilege_level < mode.currentPrivilegeLevel)
      |=> $stable(processorFlags[INTEN_POS]);
  endproperty
  a_pop_ie: assert property (p_pop_ie) else $error("interrupt enable changed without privilege");

  property p_pop32_ext;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_POP32) |=> processorFlags[ALIGN_POS] == $past(req.popData[ALIGN_POS])
      && processorFlags[FEATQ_POS] == $past(req.popData[FEATQ_POS]);
  endproperty
  a_pop32_ext: assert property (p_pop32_ext) else $error("wide pop missed extra bits");

  property p_irq_mask;
    @(posedge clk) disable iff (rst)
    !processorFlags[INTEN_POS] |=> !interruptService;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt serviced while masked");

  property p_ls_fault;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_STORE_BYTE || req.op == PFC_LOAD_BYTE) && mode.longMode && !mode.featureLoadStore)
      |=> fault && $stable(processorFlags);
  endproperty
  a_ls_fault: assert property (p_ls_fault) else $error("unsupported byte transfer not refused");

  property p_carry_set;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_SET_CARRY) |=> processorFlags[CARRY_POS];
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set");

  property p_dir_clr;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_CLR_DIR) |=>
      !processorFlags[DIR_POS] && ((processorFlags ^ $past(processorFlags)) & ~(32'h1 << DIR_POS)) == 32'h0;
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("direction clear disturbed other flags");

  property p_ie_set;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_SET_IE && ieAllowed) |=> processorFlags[INTEN_POS] && !fault;
  endproperty
  a_ie_set: assert property (p_ie_set) else $error("interrupt enable not set");

  property p_ie_refuse;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_SET_IE || req.op == PFC_CLR_IE) && !ieAllowed) |=> fault && $stable(processorFlags);
  endproperty
  a_ie_refuse: assert property (p_ie_refuse) else $error("direct interrupt enable write not refused");

  property p_irq_service;
    @(posedge clk) disable iff (rst)
    (irqSync && processorFlags[INTEN_POS]) |=> interruptService;
  endproperty
  a_irq_service: assert property (p_irq_service) else $error("enabled request not serviced");

  property p_pop_io_privilege_level_set;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_POP16 || req.op == PFC_POP32) && mode.currentPrivilegeLevel == PRIV_KERNEL)
      |=> processorFlags[IO_PRIVILEGE_LEVEL_HI_POS:IO_PRIVILEGE_LEVEL_LO_POS] == $past(req.popData[IO_PRIVILEGE_LEVEL_HI_POS:IO_PRIVILEGE_LEVEL_LO_POS]);
  endproperty
  a_pop_io_privilege_level_set: assert property (p_pop_io_privilege_level_set) else $error("kernel pop missed io privilege");

  property p_pop_ie_set;
    @(posedge clk) disable iff (rst)
    (reqValid && (req.op == PFC_POP16 || req.op == PFC_POP32) && io_privilege_level >= mode.currentPrivilegeLevel)
      |=> processorFlags[INTEN_POS] == $past(req.popData[INTEN_POS]);
  endproperty
  a_pop_ie_set: assert property (p_pop_ie_set) else $error("privileged pop missed interrupt enable");

  property p_pop16_upper;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_POP16) |=> processorFlags[31:16] == $past(processorFlags[31:16]);
  endproperty
  a_pop16_upper: assert property (p_pop16_upper) else $error("16-bit pop touched upper flags");

  property p_push32_full;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_PUSH32) |=>
      pushData[63:32] == 32'h0 && pushData[31:ALIGN_POS] == $past(processorFlags[31:ALIGN_POS]);
  endproperty
  a_push32_full: assert property (p_push32_full) else $error("wide push upper image wrong");

  property p_flags_hold;
    @(posedge clk) disable iff (rst)
    !reqValid |=> $stable(processorFlags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed without request");

  property p_done;
    @(posedge clk) disable iff (rst)
    reqValid |=> done;
  endproperty
  a_done: assert property (p_done) else $error("request not answered");

  property p_pulse_end;
    @(posedge clk) disable iff (rst)
    !reqValid |=> !done && !fault && !pushValid;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("answer pulse outlived its request");

  property p_store_upper;
    @(posedge clk) disable iff (rst)
    (reqValid && req.op == PFC_STORE_BYTE) |=> processorFlags[31:8] == $past(processorFlags[31:8]);
  endproperty
  a_store_upper: assert property (p_store_upper) else $error("byte store touched upper flags");
endmodule // pfc_flags_unit
`default_nettype wire

// file: verification/tb_top.sv
// tb_top: directed self-checking bench for the flags register unit
// assumes: pfc_pkg compiled first; outputs answer on the taking edge itself, seen just after it
`timescale 1ns/100ps
`default_nettype none
module tb_top import pfc_pkg::*; ;
  logic        clk, rst, reqValid, loadIdx, pin;
  pfc_req_t    req;
  pfc_mode_t   mode;
  logic [63:0] loadSource, loadDest, pushData, srcIdx, dstIdx;
  logic        done, fault, pushValid, intSvc;
  logic [7:0]  acc;
  logic [31:0] flags;
  int          nFail, testsRun;

  pfc_flags_unit #(.IDX_WIDTH(64)) pfc_flags_unit_inst (
    .clk(clk), .rst(rst), .reqValid(reqValid), .req(req), .mode(mode),
    .loadIdx(loadIdx), .loadSource(loadSource), .loadDest(loadDest),
    .hardwareInterruptRequestPin(pin), .done(done), .fault(fault),
    .accumulatorHighByte(acc), .pushValid(pushValid), .pushData(pushData),
    .processorFlags(flags), .interruptService(intSvc),
    .stringSourceIndex(srcIdx), .stringDestinationIndex(dstIdx));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request, answer judged just after the taking edge
  task automatic run(pfc_op_t o, logic [63:0] pd = '0, logic [7:0] ah = '0, logic f = 1'b0);
    @(posedge clk);
    reqValid <= 1'b1;
    req      <= '{op: o, popData: pd, accHigh: ah, stepSize: 3'h4};
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    chk("done", done, 1'b1);
    chk("fault", fault, f);
  endtask

  task automatic setMode(logic [1:0] c, logic lm, logic fe, logic v = 1'b0);
    @(posedge clk);
    mode <= '{currentPrivilegeLevel: c, longMode: lm, featureLoadStore: fe, v86Mode: v};
  endtask

  // pin is synchronised, so allow a few cycles, never an open wait
  task automatic waitSvc(logic e);
    for (int i = 0; i < 6; i++) begin
      if (intSvc === e) break;
      @(posedge clk);
      #1;
    end
    chk("svc", intSvc, e);
    if (intSvc !== e) summarize();
  endtask

  task automatic sCarry();
    run(PFC_SET_CARRY);
    chk("flags", flags, 32'h3);
    run(PFC_CLR_CARRY);
    chk("flags", flags, 32'h2);
    // back to back: invert must see the set just before it
    @(posedge clk);
    reqValid <= 1'b1;
    req.op   <= PFC_SET_CARRY;
    @(posedge clk);
    req.op   <= PFC_INV_CARRY;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    chk("flags", flags, 32'h2);
    run(PFC_INV_CARRY);
    chk("flags", flags, 32'h3);
    run(PFC_CLR_CARRY);
  endtask

  task automatic sDir();
    @(posedge clk);
    loadIdx    <= 1'b1;
    loadSource <= 64'h100;
    loadDest   <= 64'h200;
    @(posedge clk);
    loadIdx    <= 1'b0;
    run(PFC_STEP);
    chk("src", srcIdx, 64'h104);
    chk("dst", dstIdx, 64'h204);
    run(PFC_SET_DIR);
    chk("flags", flags, 32'h402);
    run(PFC_STEP);
    chk("src", srcIdx, 64'h100);
    chk("dst", dstIdx, 64'h200);
    run(PFC_CLR_DIR);
    chk("flags", flags, 32'h2);
  endtask

  // bits 5,3,1 of the loaded byte are masked off before comparing
  task automatic sByte();
    run(PFC_STORE_BYTE, '0, 8'hff);
    chk("flags", flags, 32'hd7);
    run(PFC_LOAD_BYTE);
    chk("acc", acc & 8'hd5, 8'hd5);
    chk("flags", flags, 32'hd7);
    run(PFC_STORE_BYTE, '0, 8'h2a);
    chk("flags", flags, 32'h2);
    run(PFC_LOAD_BYTE);
    chk("acc", acc & 8'hd5, 8'h0);
    setMode(2'h0, 1'b1, 1'b0);
    run(PFC_STORE_BYTE, '0, 8'hff, 1'b1);
    chk("flags", flags, 32'h2);
    run(PFC_LOAD_BYTE, '0, '0, 1'b1);
    setMode(2'h0, 1'b1, 1'b1);
    run(PFC_STORE_BYTE, '0, 8'hff);
    chk("flags", flags, 32'hd7);
    run(PFC_STORE_BYTE);
  endtask

  task automatic sStack();
    run(PFC_POP32, '1);
    chk("flags", flags, 32'h0024_3fd7);
    run(PFC_PUSH32);
    chk("pushValid", pushValid, 1'b1);
    chk("push32", pushData, 64'h0024_3fd7);
    run(PFC_PUSH16);
    chk("push16", pushData, 64'h3fd7);
    // io privilege 3 at level 3: enable follows the pop, privilege field does not
    setMode(2'h3, 1'b0, 1'b0);
    run(PFC_POP16, '0);
    chk("flags", flags, 32'h0024_3002);
    setMode(2'h0, 1'b0, 1'b0);
    run(PFC_POP16, '0);
    chk("flags", flags, 32'h0024_0002);
    run(PFC_POP32, '0);
    chk("flags", flags, 32'h2);
    setMode(2'h3, 1'b0, 1'b0);
    run(PFC_POP16, '1);
    chk("flags", flags, 32'hdd7);
    run(PFC_POP16, '0);
  endtask

  task automatic sIntEn();
    run(PFC_SET_IE, '0, '0, 1'b1);
    chk("flags", flags, 32'h2);
    setMode(2'h0, 1'b0, 1'b0);
    @(posedge clk);
    pin <= 1'b1;
    // let the pin clear both sync stages before judging the mask
    repeat (4) @(posedge clk);
    #1;
    waitSvc(1'b0);
    run(PFC_SET_IE);
    chk("flags", flags, 32'h202);
    waitSvc(1'b1);
    run(PFC_CLR_IE);
    chk("flags", flags, 32'h2);
    waitSvc(1'b0);
    // v86 refuses direct writes even with full privilege
    setMode(2'h0, 1'b0, 1'b0, 1'b1);
    run(PFC_SET_IE, '0, '0, 1'b1);
    chk("flags", flags, 32'h2);
  endtask

  initial begin
    nFail      = 0;
    testsRun   = 0;
    rst        = 1'b1;
    reqValid   = 1'b0;
    req        = '0;
    mode       = '0;
    loadIdx    = 1'b0;
    loadSource = '0;
    loadDest   = '0;
    pin        = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset", flags, 32'h2);
    sCarry();
    sDir();
    sByte();
    setMode(2'h0, 1'b0, 1'b0);
    sStack();
    sIntEn();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
